/* File: hw/pss_seq.sv */
// three-channel script sequencer: sync trigger and end instruction handling
// assumes i_tick pulses once per 32 kHz sequencer cycle; other opcodes
// advance in one tick (their timing belongs to other logic)
// Behaviour
// - send-only sync takes exactly sixteen ticks
// - wait sync takes at least sixteen ticks
// - waiting channel holds its script position
// - satisfied wait clears its triggers, advances
// - sent trigger stays latched until waited
// - top bits 111 decode as sync
// - wait field bits select channels 0..2
// - send field bits select channels 0..2
// - end instruction stops the channel
// - end raises request only with int bit
// - int bit sets channel script-done flag
// - end with level bit set drives output to idle polarity
// - level bit low drives low, else polarity
// - end returns pointer to first location
// - halted during wait: no end, no request
// - top bits 110 decode as end
// - last location without end forces end
// - each channel has 31-entry buffer
`timescale 1ns/1ps
module pss_seq
  import pss_pkg::*;
#(
  parameter int SYNC_LEN = SYNC_TICKS
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic              i_tick,
  input  wire pss_load_s         i_load,
  input  wire logic [NUM_CH-1:0] i_start,
  input  wire logic [NUM_CH-1:0] i_halt,
  input  wire logic [NUM_CH-1:0] i_channel_idle_polarity,
  input  wire logic [NUM_CH-1:0] i_done_clr,
  input  wire logic [NUM_CH-1:0] i_pwm_level,
  output logic [NUM_CH-1:0]      o_pwm,
  output logic [NUM_CH-1:0]      o_script_done_flag,
  output logic [NUM_CH-1:0]      o_running
);

  // ----------------------------------------------------------------
  // script buffers
  // ----------------------------------------------------------------
  logic [INSN_W-1:0] buf_mem [NUM_CH][BUF_DEPTH];

  always_ff @(posedge i_ref_clk) begin
    if (i_ce && i_load.wr && i_load.addr <= ADDR_LAST) begin
      buf_mem[i_load.ch][i_load.addr] <= i_load.data;
    end
  end

  function automatic logic is_sync(input logic [INSN_W-1:0] w);
    return w[OPC_HI:OPC_LO] == OPC_SYNC;
  endfunction : is_sync

  function automatic logic is_end(input logic [INSN_W-1:0] w);
    return w[OPC_HI:OPC_LO] == OPC_END;
  endfunction : is_end

  // ----------------------------------------------------------------
  // per-channel sequencers
  // ----------------------------------------------------------------
  pss_state_e          state_reg [NUM_CH];
  logic [ADDR_W-1:0]   pc_reg    [NUM_CH];
  logic [4:0]          cnt_reg   [NUM_CH];
  logic [NUM_CH-1:0]   trig_reg  [NUM_CH]; // [receiver][sender]
  logic [INSN_W-1:0]   insn      [NUM_CH];
  logic [NUM_CH-1:0]   wsel      [NUM_CH];
  logic [NUM_CH-1:0]   ssel      [NUM_CH];
  logic [NUM_CH-1:0]   send_now;
  logic [NUM_CH-1:0]   wait_ok;
  logic [NUM_CH-1:0]   sync_fin;
  logic [NUM_CH-1:0]   end_now;
  logic [NUM_CH-1:0]   end_int;
  logic [NUM_CH-1:0]   end_lvl;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      // last location without end is replaced by forced end
      if (pc_reg[c] == ADDR_LAST && !is_end(buf_mem[c][pc_reg[c]])) begin
        insn[c] = FORCED_END;
      end else begin
        insn[c] = buf_mem[c][pc_reg[c]];
      end
      wsel[c] = insn[c][WAIT_LO+NUM_CH-1:WAIT_LO];
      ssel[c] = insn[c][SEND_LO+NUM_CH-1:SEND_LO];
      wait_ok[c] = (trig_reg[c] & wsel[c]) == wsel[c];
      sync_fin[c] = i_tick && state_reg[c] == PSS_SYNC &&
                    cnt_reg[c] >= 5'(SYNC_LEN - 1) && wait_ok[c];
      send_now[c] = sync_fin[c] && !i_halt[c];
      end_now[c] = i_tick && state_reg[c] == PSS_RUN && !i_halt[c] &&
                   is_end(insn[c]);
      end_int[c] = insn[c][END_INT_BIT];
      end_lvl[c] = insn[c][END_LVL_BIT];
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic [NUM_CH-1:0] inc;
    logic [NUM_CH-1:0] clr;
    always_comb begin
      for (int s = 0; s < NUM_CH; s++) begin
        inc[s] = send_now[s] && ssel[s][g];
      end
      clr = sync_fin[g] && !i_halt[g] ? wsel[g] : '0;
    end

    // trigger latches, a new send wins over a clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        trig_reg[g] <= '0;
      end else if (i_ce) begin
        trig_reg[g] <= (trig_reg[g] & ~clr) | inc;
      end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        state_reg[g] <= PSS_IDLE;
        pc_reg[g]    <= ADDR_FIRST;
        cnt_reg[g]   <= '0;
      end else if (i_ce) begin
        unique case (state_reg[g])
          PSS_IDLE: begin
            if (i_start[g]) begin
              state_reg[g] <= PSS_RUN;
            end
          end
          PSS_RUN: begin
            if (i_halt[g]) begin
              state_reg[g] <= PSS_IDLE;
            end else if (i_tick) begin
              if (is_end(insn[g])) begin
                state_reg[g] <= PSS_IDLE;
                pc_reg[g]    <= ADDR_FIRST;
              end else if (is_sync(insn[g])) begin
                state_reg[g] <= PSS_SYNC;
                // executing tick is the first of the sixteen
                cnt_reg[g]   <= 5'h01;
              end else begin
                pc_reg[g] <= pc_reg[g] + 5'h01;
              end
            end
          end
          PSS_SYNC: begin
            if (i_halt[g]) begin
              state_reg[g] <= PSS_IDLE;
            end else if (sync_fin[g]) begin
              state_reg[g] <= PSS_RUN;
              pc_reg[g]    <= pc_reg[g] + 5'h01;
            end else if (i_tick) begin
              // hold position while waiting
              if (cnt_reg[g] < 5'(SYNC_LEN - 1)) begin
                cnt_reg[g] <= cnt_reg[g] + 5'h01;
              end
            end
          end
          default: state_reg[g] <= PSS_IDLE;
        endcase
      end
    end

    // output level and done flag
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        o_pwm[g] <= 1'b0;
      end else if (i_ce) begin
        if (end_now[g]) begin
          o_pwm[g] <= end_lvl[g] ? i_channel_idle_polarity[g]
                                 : 1'b0;
        end else if (state_reg[g] != PSS_IDLE) begin
          o_pwm[g] <= i_pwm_level[g];
        end
      end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        o_script_done_flag[g] <= 1'b0;
      end else if (i_ce) begin
        if (end_now[g] && end_int[g]) begin
          o_script_done_flag[g] <= 1'b1;
        end else if (i_done_clr[g]) begin
          o_script_done_flag[g] <= 1'b0;
        end
      end
    end

    // ----------------------------------------------------------------
    // tick count on the current sync, for the timing checks
    // ----------------------------------------------------------------
    logic [5:0] chk_ticks;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        chk_ticks <= '0;
      end else if (i_ce && i_tick) begin
        if (state_reg[g] == PSS_RUN && !i_halt[g] && is_sync(insn[g])) begin
          chk_ticks <= 6'h01;
        end else if (state_reg[g] == PSS_SYNC && chk_ticks != '1) begin
          chk_ticks <= chk_ticks + 6'h01;
        end
      end
    end

    assign o_running[g] = state_reg[g] != PSS_IDLE;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_done_needs_int;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(o_script_done_flag[g]) |-> $past(end_now[g] && end_int[g]);
    endproperty
    a_done_needs_int: assert property (p_done_needs_int)
      else $error("done flag set without enabled end");

    property p_end_sets_done;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && end_now[g] && end_int[g] |=> o_script_done_flag[g];
    endproperty
    a_end_sets_done: assert property (p_end_sets_done)
      else $error("enabled end did not set done flag");

    property p_end_level;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && end_now[g] |=>
          o_pwm[g] == ($past(end_lvl[g]) &
                       $past(i_channel_idle_polarity[g]));
    endproperty
    a_end_level: assert property (p_end_level)
      else $error("wrong output level after end");

    property p_end_resets_pc;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && end_now[g] |=> pc_reg[g] == ADDR_FIRST &&
                               state_reg[g] == PSS_IDLE;
    endproperty
    a_end_resets_pc: assert property (p_end_resets_pc)
      else $error("end did not stop and rewind");

    property p_sync_min;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        sync_fin[g] |-> chk_ticks >= 6'(SYNC_LEN - 1) &&
                        (|wsel[g] || chk_ticks == 6'(SYNC_LEN - 1));
    endproperty
    a_sync_min: assert property (p_sync_min)
      else $error("sync finished before sixteen ticks");

    property p_wait_holds;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && state_reg[g] == PSS_SYNC && !sync_fin[g]
          |=> $stable(pc_reg[g]);
    endproperty
    a_wait_holds: assert property (p_wait_holds)
      else $error("pointer moved during wait");

    property p_wait_clears;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && sync_fin[g] && !i_halt[g] && !(|inc)
          |=> (trig_reg[g] & $past(wsel[g])) == '0;
    endproperty
    a_wait_clears: assert property (p_wait_clears)
      else $error("satisfied wait kept its triggers");

    property p_trig_kept;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && !(sync_fin[g] && !i_halt[g]) |=>
          (trig_reg[g] & $past(trig_reg[g])) == $past(trig_reg[g]);
    endproperty
    a_trig_kept: assert property (p_trig_kept)
      else $error("trigger lost without wait");

    property p_halt_no_done;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && state_reg[g] == PSS_SYNC && i_halt[g] && !o_script_done_flag[g]
          |=> !o_script_done_flag[g];
    endproperty
    a_halt_no_done: assert property (p_halt_no_done)
      else $error("halted wait raised done flag");

    property p_send_due;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && i_tick && state_reg[g] == PSS_SYNC && wsel[g] == '0 &&
          chk_ticks == 6'(SYNC_LEN - 1) |-> sync_fin[g];
    endproperty
    a_send_due: assert property (p_send_due)
      else $error("send-only sync did not end on time");

    property p_sync_entry;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && i_tick && state_reg[g] == PSS_RUN && !i_halt[g] &&
          insn[g][OPC_HI:OPC_LO] == OPC_SYNC |=> state_reg[g] == PSS_SYNC;
    endproperty
    a_sync_entry: assert property (p_sync_entry)
      else $error("sync opcode not decoded");

    property p_trig_set;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_ce && |inc |=> (trig_reg[g] & $past(inc)) == $past(inc);
    endproperty
    a_trig_set: assert property (p_trig_set)
      else $error("sent trigger not latched");

    c_end_int: cover property (@(posedge i_ref_clk) end_now[g] && end_int[g]);
    c_wait_done: cover property (@(posedge i_ref_clk) sync_fin[g] && |wsel[g]);
    c_forced: cover property (@(posedge i_ref_clk)
                              end_now[g] && pc_reg[g] == ADDR_LAST);
    c_halt_wait: cover property (@(posedge i_ref_clk)
                                 state_reg[g] == PSS_SYNC && i_halt[g]);
  end

endmodule : pss_seq

/* File: pkg/pss_pkg.sv */
// package for the pwm script sync and end block
// assumes a 100 MHz system clock with a 32 kHz sequencer tick enable
package pss_pkg;
  localparam int          NUM_CH        = 3;
  localparam int          BUF_DEPTH     = 31;
  localparam int          ADDR_W        = 5;
  localparam int          INSN_W        = 16;
  localparam int          SYNC_TICKS    = 16;
  localparam logic [4:0]  ADDR_FIRST    = 5'h00;
  localparam logic [4:0]  ADDR_LAST     = 5'h1e;
  localparam logic [2:0]  OPC_SYNC      = 3'h7;
  localparam logic [2:0]  OPC_END       = 3'h6;
  localparam int          OPC_HI        = 15;
  localparam int          OPC_LO        = 13;
  localparam int          WAIT_HI       = 12;
  localparam int          WAIT_LO       = 7;
  localparam int          SEND_HI       = 6;
  localparam int          SEND_LO       = 1;
  localparam int          END_INT_BIT   = 12;
  localparam int          END_LVL_BIT   = 11;
  localparam logic [15:0] FORCED_END    = 16'hd800;

  typedef enum logic [1:0] {
    PSS_IDLE = 2'b00,
    PSS_RUN  = 2'b01,
    PSS_SYNC = 2'b10
  } pss_state_e;

  typedef struct packed {
    logic       wr;
    logic [1:0] ch;
    logic [4:0] addr;
    logic [15:0] data;
  } pss_load_s;
endpackage : pss_pkg

/* File: tb/pss_led_model.sv */
// lamp load on the pwm outputs: registers drive level as lamp state
// assumes drive comes straight from the sequencer outputs
`timescale 1ns/1ps
module pss_led_model
  import pss_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic [NUM_CH-1:0] i_drive,
  output logic [NUM_CH-1:0]      o_lit
);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_lit <= '0;
    else o_lit <= i_drive;
  end
endmodule : pss_led_model

/* File: tb/tb_pss_seq.sv */
// self-checking bench for the script sequencer sync and end logic
// assumes ticks are driven by the bench, one tick per two clocks
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  err_total++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_pss_seq;
  import pss_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst_n   = 1'b0;
  logic              tick    = 1'b0;
  pss_load_s         load    = '0;
  logic [NUM_CH-1:0] start   = '0;
  logic [NUM_CH-1:0] halt    = '0;
  logic [NUM_CH-1:0] clr     = '0;
  logic [NUM_CH-1:0] pol     = 3'h7;
  logic [NUM_CH-1:0] lvl     = 3'h0;
  logic [NUM_CH-1:0] pwm, done, run, lit;
  int                err_total = 0;
  int                cmp_count = 0;
  int                cyc       = 0;
  // ------------------------------------------------------------
  // design and lamp load
  // ------------------------------------------------------------
  pss_seq u_pss_seq (
    .i_ref_clk               (ref_clk),
    .i_rst_n                 (rst_n),
    .i_ce                    (1'b1),
    .i_tick                  (tick),
    .i_load                  (load),
    .i_start                 (start),
    .i_halt                  (halt),
    .i_channel_idle_polarity (pol),
    .i_done_clr              (clr),
    .i_pwm_level             (lvl),
    .o_pwm                   (pwm),
    .o_script_done_flag      (done),
    .o_running               (run)
  );
  pss_led_model u_pss_led_model (
    .i_ref_clk (ref_clk),
    .i_rst_n   (rst_n),
    .i_drive   (pwm),
    .o_lit     (lit)
  );
  always #5 ref_clk = ~ref_clk;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic ld(input int c, input int a, input logic [15:0] d);
    @(posedge ref_clk);
    load <= '{1'b1, 2'(c), 5'(a), d};
  endtask : ld
  task automatic tk();
    @(posedge ref_clk);
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
    #1;
  endtask : tk
  task automatic go(input int c, input int n, input logic f);
    @(posedge ref_clk);
    load.wr  <= 1'b0;
    start[c] <= 1'b1;
    clr[c]   <= 1'b1;
    @(posedge ref_clk);
    start <= '0;
    clr   <= '0;
    repeat (n - 1) tk();
    `CHK("flag early", 1'b0, done[c])
    tk();
    `CHK("flag", f, done[c])
  endtask : go
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_send();
    ld(0, 0, 16'he004);
    ld(0, 1, 16'hd800);
    go(0, 17, 1'b1);
    `CHK("pwm0", 1'b1, pwm[0])
    `CHK("run0", 1'b0, run[0])
    @(posedge ref_clk);
    #1;
    `CHK("lit0", 1'b1, lit[0])
    $display("test send done");
  endtask : test_send
  task automatic test_wait();
    // running level high so a low end level is visible
    @(posedge ref_clk);
    lvl <= 3'h7;
    ld(1, 0, 16'he080);
    ld(1, 1, 16'hd000);
    go(1, 17, 1'b1);
    `CHK("pwm1", 1'b0, pwm[1])
    go(1, 40, 1'b0);
    `CHK("run1", 1'b1, run[1])
    @(posedge ref_clk);
    halt[1] <= 1'b1;
    tk();
    tk();
    @(posedge ref_clk);
    halt[1] <= 1'b0;
    #1;
    `CHK("run1 halt", 1'b0, run[1])
    `CHK("flag1 halt", 1'b0, done[1])
    go(0, 17, 1'b1);
    go(1, 17, 1'b1);
    $display("test wait done");
  endtask : test_wait
  task automatic test_end();
    @(posedge ref_clk);
    lvl <= 3'h0;
    ld(2, 0, 16'hc800);
    go(2, 1, 1'b0);
    `CHK("pwm2", 1'b1, pwm[2])
    // low polarity with a high running level
    @(posedge ref_clk);
    pol <= 3'h3;
    lvl <= 3'h7;
    go(2, 1, 1'b0);
    `CHK("pwm2 pol", 1'b0, pwm[2])
    @(posedge ref_clk);
    pol <= 3'h7;
    lvl <= 3'h0;
    `CHK("run2", 1'b0, run[2])
    for (int a = 0; a < BUF_DEPTH; a++) ld(2, a, 16'h4000);
    go(2, 31, 1'b1);
    `CHK("pwm2 forced", 1'b1, pwm[2])
    $display("test end done");
  endtask : test_end
  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_send();
    test_wait();
    test_end();
    print_verdict();
  end
endmodule : tb_pss_seq
